// *** logic/cmi_core.sv ***
`timescale 1ns/100ps
module cmi_core
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic host_connection_enable_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] transmit_byte_register_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic sram_transfer_ok_i,
  output logic [31:0] status_word_o,
  output logic user_ports_taken_o,
  output logic user_io_tristate_o,
  output logic user_logic_halt_o
);
  cmi_pkg::cmi_state_t state;
  logic frame_d;
  logic [7:0] op;
  logic [2:0] opnd_cnt;
  logic [7:0] opnd0;
  logic [cmi_pkg::MEM_PAGES-1:0] page_live;
  logic [31:0] shreg;
  logic [3:0] data_cnt;
  logic enabled;
  logic offline;
  logic ports_taken;
  logic busy;
  logic fail;
  logic nv_done;
  logic [15:0] busy_cnt;
  logic [1:0] sector;
  logic [13:0] page_addr;
  logic [7:0] pages_left;
  logic [3:0] byte_idx;
  logic [1:0] bcnt;
  logic [7:0] gen_byte;
  logic gen_valid;
  logic gen_from_mem;
  logic [1:0] out_cnt;
  logic [7:0] out_buf [0:1];
  logic out_wr;
  logic out_rd;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic rd_pend;
  logic byte_take;
  logic frame_start;
  logic need_en;
  logic known_op;

  function automatic logic [9:0] mem_index(input logic [1:0] sec,
    input logic [13:0] pg, input logic [3:0] b);
    mem_index = {sec[0], pg[4:0], b};
  endfunction

  assign frame_start = host_connection_enable_i && !frame_d;
  assign tx_ready_o = (state != cmi_pkg::CMI_DATA) || !rd_pend;
  assign byte_take = tx_valid_i && tx_ready_o && host_connection_enable_i;
  assign rx_valid_o = out_cnt != 2'h0;
  assign rx_data_o = out_buf[0];
  assign out_rd = rx_valid_o && rx_ready_i;
  assign out_wr = gen_valid && (out_cnt != 2'h2);
  assign status_word_o = {18'h0, fail, busy, 2'h0, enabled,
    enabled ? nv_done : sram_transfer_ok_i, 8'h0};
  assign user_ports_taken_o = ports_taken;
  assign user_io_tristate_o = offline;
  assign user_logic_halt_o = offline;

  always_comb
  begin
    need_en = 1'b0;
    known_op = 1'b1;
    case (op)
      cmi_pkg::OP_ERASE, cmi_pkg::OP_ADDR_LOAD, cmi_pkg::OP_USER_ADDR_RST,
      cmi_pkg::OP_CFG_ADDR_RST, cmi_pkg::OP_USER_READ,
      cmi_pkg::OP_USER_PROG, cmi_pkg::OP_CFG_READ, cmi_pkg::OP_CFG_PROG:
        need_en = 1'b1;
      cmi_pkg::OP_STATUS_READ, cmi_pkg::OP_BUSY_CHECK, cmi_pkg::OP_TRACE_ID,
      cmi_pkg::OP_ID_READ, cmi_pkg::OP_ID_COMPARE, cmi_pkg::OP_NULL,
      cmi_pkg::OP_TRANSPARENT_EN, cmi_pkg::OP_OFFLINE_EN,
      cmi_pkg::OP_DISABLE:
        need_en = 1'b0;
      default:
        known_op = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_d <= 1'b0;
    end
    else
    begin
      frame_d <= host_connection_enable_i;
    end
  end

  // Frame parser: opcode, three operands, then payload bytes.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= cmi_pkg::CMI_IDLE;
      op <= 8'h00;
      opnd_cnt <= 3'h0;
      opnd0 <= 8'h00;
    end
    else if (!host_connection_enable_i || frame_start)
    begin
      state <= cmi_pkg::CMI_IDLE;
      opnd_cnt <= 3'h0;
    end
    else if (byte_take)
    begin
      case (state)
        cmi_pkg::CMI_IDLE:
        begin
          op <= transmit_byte_register_i;
          state <= cmi_pkg::CMI_OPER;
        end
        cmi_pkg::CMI_OPER:
        begin
          opnd_cnt <= opnd_cnt + 3'h1;
          if (opnd_cnt == 3'h0)
          begin
            opnd0 <= transmit_byte_register_i;
          end
          if (opnd_cnt == 3'h2)
          begin
            state <= (!known_op || (need_en && !enabled))
              ? cmi_pkg::CMI_SKIP : cmi_pkg::CMI_DATA;
          end
        end
        cmi_pkg::CMI_DATA, cmi_pkg::CMI_SKIP:
          state <= state;
        default:
          state <= cmi_pkg::CMI_IDLE;
      endcase
    end
  end

  wire exec = byte_take && state == cmi_pkg::CMI_OPER && opnd_cnt == 3'h2;
  wire exec_ok = exec && known_op && !(need_en && !enabled);
  wire in_data = byte_take && state == cmi_pkg::CMI_DATA;
  wire disable_ok = byte_take && state == cmi_pkg::CMI_OPER &&
    opnd_cnt == 3'h1 && op == cmi_pkg::OP_DISABLE && !busy;

  // Enable state, access mode and taken-over ports.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      enabled <= 1'b0;
      offline <= 1'b0;
      ports_taken <= 1'b0;
    end
    else if (disable_ok)
    begin
      enabled <= 1'b0;
      offline <= 1'b0;
    end
    else if (exec_ok && op == cmi_pkg::OP_TRANSPARENT_EN)
    begin
      enabled <= 1'b1;
      ports_taken <= 1'b1;
    end
    else if (exec_ok && op == cmi_pkg::OP_OFFLINE_EN)
    begin
      enabled <= 1'b1;
      offline <= 1'b1;
      ports_taken <= 1'b1;
    end
    else if (byte_take && state == cmi_pkg::CMI_IDLE &&
      transmit_byte_register_i == cmi_pkg::OP_NULL && !enabled)
    begin
      ports_taken <= 1'b0;
    end
  end

  // Busy timer and fail flag; each ID compare overwrites fail with its result.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_cnt <= 16'h0000;
      busy <= 1'b0;
      fail <= 1'b0;
      nv_done <= 1'b0;
    end
    else
    begin
      if (exec_ok && (op == cmi_pkg::OP_ERASE ||
        op == cmi_pkg::OP_TRANSPARENT_EN || op == cmi_pkg::OP_OFFLINE_EN))
      begin
        busy_cnt <= cmi_pkg::BUSY_CYC16;
        busy <= 1'b1;
        if (op == cmi_pkg::OP_ERASE && opnd0[cmi_pkg::ER_CFG])
        begin
          nv_done <= 1'b0;
        end
      end
      else if (busy_cnt != 16'h0000)
      begin
        busy_cnt <= busy_cnt - 16'h0001;
        busy <= busy_cnt != 16'h0001;
      end
      if (in_data && op == cmi_pkg::OP_ID_COMPARE && data_cnt == 4'h3)
      begin
        fail <= {shreg[23:0], transmit_byte_register_i} !=
          cmi_pkg::DEV_ID;
      end
    end
  end

  // Page address: sector select plus 14-bit page, post-incremented.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sector <= cmi_pkg::SEC_CFG;
      page_addr <= 14'h0000;
      shreg <= 32'h0000_0000;
      data_cnt <= 4'h0;
    end
    else if (exec_ok)
    begin
      data_cnt <= 4'h0;
      if (op == cmi_pkg::OP_USER_ADDR_RST)
      begin
        sector <= cmi_pkg::SEC_USER;
        page_addr <= 14'h0000;
      end
      if (op == cmi_pkg::OP_CFG_ADDR_RST || op == cmi_pkg::OP_CFG_READ)
      begin
        sector <= cmi_pkg::SEC_CFG;
        if (op == cmi_pkg::OP_CFG_ADDR_RST)
        begin
          page_addr <= 14'h0000;
        end
      end
    end
    else if (in_data)
    begin
      shreg <= {shreg[23:0], transmit_byte_register_i};
      data_cnt <= data_cnt + 4'h1;
      if (op == cmi_pkg::OP_ADDR_LOAD && data_cnt == 4'h3)
      begin
        sector <= shreg[22] ? cmi_pkg::SEC_USER : cmi_pkg::SEC_CFG;
        page_addr <= {shreg[5:0], transmit_byte_register_i};
      end
      if ((op == cmi_pkg::OP_USER_PROG || op == cmi_pkg::OP_CFG_PROG) &&
        data_cnt == cmi_pkg::PAGE_LAST)
      begin
        page_addr <= page_addr + 14'h0001;
      end
    end
    else if (gen_from_mem && out_wr && byte_idx == cmi_pkg::PAGE_LAST)
    begin
      page_addr <= page_addr + 14'h0001;
    end
  end

  assign mem_we = in_data && (op == cmi_pkg::OP_USER_PROG ||
    op == cmi_pkg::OP_CFG_PROG);
  wire [9:0] waddr = mem_index(sector, page_addr, data_cnt);

  // One flag per page: an erased or never programmed page reads as zeros.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      page_live <= '0;
    end
    else if (exec_ok && op == cmi_pkg::OP_ERASE)
    begin
      if (opnd0[cmi_pkg::ER_USER])
      begin
        page_live[cmi_pkg::MEM_PAGES-1 -: cmi_pkg::MEM_PAGES/2] <= '0;
      end
      if (opnd0[cmi_pkg::ER_CFG])
      begin
        page_live[0 +: cmi_pkg::MEM_PAGES/2] <= '0;
      end
    end
    else if (mem_we)
    begin
      page_live[waddr[9:4]] <= 1'b1;
    end
  end

  // Read generator: stream of answer bytes into the two-entry buffer.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gen_from_mem <= 1'b0;
      pages_left <= 8'h00;
      byte_idx <= 4'h0;
      bcnt <= 2'h0;
      gen_valid <= 1'b0;
      gen_byte <= 8'h00;
      rd_pend <= 1'b0;
    end
    else if (!host_connection_enable_i)
    begin
      gen_valid <= 1'b0;
      gen_from_mem <= 1'b0;
      rd_pend <= 1'b0;
    end
    else if (exec_ok && (op == cmi_pkg::OP_USER_READ ||
      op == cmi_pkg::OP_CFG_READ))
    begin
      // The page count is the last operand, taken on this same edge.
      gen_from_mem <= transmit_byte_register_i != 8'h00;
      pages_left <= transmit_byte_register_i;
      byte_idx <= 4'h0;
      bcnt <= 2'h0;
      rd_pend <= transmit_byte_register_i != 8'h00;
    end
    else if (exec_ok && (op == cmi_pkg::OP_STATUS_READ ||
      op == cmi_pkg::OP_ID_READ || op == cmi_pkg::OP_TRACE_ID ||
      op == cmi_pkg::OP_BUSY_CHECK))
    begin
      gen_valid <= 1'b1;
      byte_idx <= 4'h0;
      case (op)
        cmi_pkg::OP_STATUS_READ: gen_byte <= status_word_o[31:24];
        cmi_pkg::OP_ID_READ: gen_byte <= cmi_pkg::DEV_ID[31:24];
        cmi_pkg::OP_TRACE_ID: gen_byte <= cmi_pkg::TRACE_ID[63:56];
        default: gen_byte <= {7'h00, busy};
      endcase
      bcnt <= 2'h0;
    end
    else if (gen_valid && out_wr && !gen_from_mem)
    begin
      byte_idx <= byte_idx + 4'h1;
      case (op)
        cmi_pkg::OP_STATUS_READ:
          gen_byte <= status_word_o[8'(23 - 8 * byte_idx) -: 8];
        cmi_pkg::OP_ID_READ:
          gen_byte <= cmi_pkg::DEV_ID[8'(23 - 8 * byte_idx) -: 8];
        default:
          gen_byte <= cmi_pkg::TRACE_ID[8'(55 - 8 * byte_idx) -: 8];
      endcase
      gen_valid <= (op == cmi_pkg::OP_TRACE_ID) ? byte_idx != 4'h7 :
        (op != cmi_pkg::OP_BUSY_CHECK && byte_idx != 4'h3);
    end
    else if (gen_from_mem)
    begin
      bcnt <= gen_valid ? 2'h0 : bcnt + 2'h1;
      if (!gen_valid && bcnt == 2'h1)
      begin
        gen_valid <= 1'b1;
        gen_byte <= page_live[{sector[0], page_addr[4:0]}] ?
          mem_rdata : 8'h00;
      end
      else if (gen_valid && out_wr)
      begin
        gen_valid <= 1'b0;
        byte_idx <= byte_idx + 4'h1;
        if (byte_idx == cmi_pkg::PAGE_LAST)
        begin
          pages_left <= pages_left - 8'h01;
          gen_from_mem <= pages_left != 8'h01;
          rd_pend <= pages_left != 8'h01;
        end
      end
    end
  end

  // Two-entry answer buffer; a receiver stall holds the generator.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_cnt <= 2'h0;
      out_buf[0] <= 8'h00;
      out_buf[1] <= 8'h00;
    end
    else
    begin
      if (out_rd)
      begin
        out_buf[0] <= out_buf[1];
      end
      if (out_wr)
      begin
        if (out_cnt == 2'h0 || (out_cnt == 2'h1 && out_rd))
        begin
          out_buf[0] <= gen_byte;
        end
        else
        begin
          out_buf[out_rd ? 0 : 1] <= gen_byte;
        end
      end
      out_cnt <= out_cnt + {1'b0, out_wr} - {1'b0, out_rd};
    end
  end

  cmi_page_mem cmi_page_mem_i
  (
    .clk_sys_i(clk_sys_i),
    .we_i(mem_we),
    .waddr_i(waddr),
    .wdata_i(transmit_byte_register_i),
    .raddr_i(mem_index(sector, page_addr, byte_idx)),
    .rdata_o(mem_rdata)
  );

  sequence busy_start_s;
    exec_ok && op == cmi_pkg::OP_ERASE;
  endsequence
  busy_flag_set_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) busy_start_s |=> status_word_o[cmi_pkg::ST_BUSY])
    else $error("busy not raised after erase");
  disable_block_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) busy && enabled |=> enabled)
    else $error("left enabled state while busy");
  enable_bit_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) disable_ok |=> !status_word_o[cmi_pkg::ST_ENABLE])
    else $error("enable bit still set after disable");
  gate_reject_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) exec && need_en && !enabled |=> !busy && !mem_we)
    else $error("flagged command ran while disabled");
  addr_reset_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) exec_ok && op == cmi_pkg::OP_USER_ADDR_RST
    |=> page_addr == 14'h0000 && sector == cmi_pkg::SEC_USER)
    else $error("user address reset failed");
  unknown_keep_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) state == cmi_pkg::CMI_SKIP
    |=> $stable(page_addr) && $stable(enabled) && !mem_we)
    else $error("unknown opcode had effect");
  offline_io_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) exec_ok && op == cmi_pkg::OP_OFFLINE_EN
    |=> user_io_tristate_o && user_logic_halt_o)
    else $error("offline mode missing");
  ports_hold_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) $fell(ports_taken) |-> !enabled)
    else $error("ports restored while enabled");
endmodule

// *** logic/cmi_page_mem.sv ***
`timescale 1ns/100ps
module cmi_page_mem
(
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [9:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [9:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:1023];

  always_ff @(posedge clk_sys_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// *** logic/cmi_pkg.sv ***
package cmi_pkg;
  // Opcodes.
  localparam logic [7:0] OP_TRANSPARENT_EN = 8'h74;
  localparam logic [7:0] OP_OFFLINE_EN = 8'hC6;
  localparam logic [7:0] OP_DISABLE = 8'h26;
  localparam logic [7:0] OP_NULL = 8'hFF;
  localparam logic [7:0] OP_STATUS_READ = 8'h3C;
  localparam logic [7:0] OP_BUSY_CHECK = 8'hF0;
  localparam logic [7:0] OP_ERASE = 8'h0E;
  localparam logic [7:0] OP_TRACE_ID = 8'h19;
  localparam logic [7:0] OP_ADDR_LOAD = 8'hB4;
  localparam logic [7:0] OP_USER_ADDR_RST = 8'h47;
  localparam logic [7:0] OP_CFG_ADDR_RST = 8'h46;
  localparam logic [7:0] OP_USER_READ = 8'hCA;
  localparam logic [7:0] OP_USER_PROG = 8'hC9;
  localparam logic [7:0] OP_CFG_READ = 8'h73;
  localparam logic [7:0] OP_CFG_PROG = 8'h70;
  localparam logic [7:0] OP_ID_COMPARE = 8'hE2;
  localparam logic [7:0] OP_ID_READ = 8'hE0;
  // Geometry.
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W = 14;
  localparam int MEM_PAGES = 64;
  localparam int MEM_AW = 10;
  localparam logic [3:0] PAGE_LAST = 4'hF;
  // Status word bit positions.
  localparam int ST_DONE = 8;
  localparam int ST_ENABLE = 9;
  localparam int ST_BUSY = 12;
  localparam int ST_FAIL = 13;
  // Erase select bits in first operand.
  localparam int ER_USER = 3;
  localparam int ER_CFG = 2;
  localparam int ER_FEAT = 1;
  localparam int ER_SRAM = 0;
  // Operation busy time.
  localparam int BUSY_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int BUSY_CYC = BUSY_NS / CLK_NS;
  localparam logic [15:0] BUSY_CYC16 = 16'(BUSY_CYC);
  // Identity values; values are arbitrary.
  localparam logic [31:0] DEV_ID = 32'h1234_5678;
  localparam logic [63:0] TRACE_ID = 64'hA5_0011_2233_4455_66;
  localparam logic [1:0] SEC_CFG = 2'h0;
  localparam logic [1:0] SEC_USER = 2'h1;
  localparam logic [1:0] SEC_FEAT = 2'h2;
  typedef struct packed {
    logic [7:0] data;
    logic first;
  } cmi_byte_t;
  typedef enum logic [2:0] {
    CMI_IDLE = 3'h0,
    CMI_OPER = 3'h1,
    CMI_DATA = 3'h3,
    CMI_SKIP = 3'h2
  } cmi_state_t;
endpackage

// *** tb/cmi_core_tb.sv ***
`timescale 1ns/100ps
module cmi_core_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic conn = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic sram_ok = 1'b1;
  logic stall = 1'b0;
  logic tx_ready, rx_valid, rx_ready, taken, tri_o, halt;
  logic [7:0] rx_data;
  logic [31:0] status;
  logic [7:0] q[$];
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  cmi_core cmi_core_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .host_connection_enable_i(conn), .tx_valid_i(tx_valid),
    .transmit_byte_register_i(tx_data), .tx_ready_o(tx_ready),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
    .sram_transfer_ok_i(sram_ok), .status_word_o(status),
    .user_ports_taken_o(taken), .user_io_tristate_o(tri_o),
    .user_logic_halt_o(halt));
  cmi_host_rx cmi_host_rx_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .stall_i(stall), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_ready_o(rx_ready));

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The whole sequence needs somewhat over a thousand cycles; this cuts a hang short.
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [7:0] b);
    tx_valid <= 1'b1;
    tx_data <= b;
    @(negedge clk_sys_i);
    while (tx_ready !== 1'b1)
      @(negedge clk_sys_i);
    @(posedge clk_sys_i);
  endtask

  // Sends the bytes held in q as one framed command and collects n answers.
  task automatic frame(input int n);
    cmi_host_rx_i.got.delete();
    conn <= 1'b1;
    @(posedge clk_sys_i);
    foreach (q[i])
      put(q[i]);
    tx_valid <= 1'b0;
    while (cmi_host_rx_i.got.size() < n)
      @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
    check(cmi_host_rx_i.got.size(), n);
    conn <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  function automatic logic [63:0] val(input int n);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < n; i++)
      v = {v[55:0], cmi_host_rx_i.got[i]};
    return v;
  endfunction

  task automatic status_rd(input logic [31:0] exp, input logic [31:0] mask);
    q = '{cmi_pkg::OP_STATUS_READ, 8'h00, 8'h00, 8'h00};
    frame(4);
    check(32'(val(4)) & mask, exp);
    check(status & mask, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (status[cmi_pkg::ST_BUSY] !== 1'b0)
    begin
      n++;
      @(posedge clk_sys_i);
    end
    check(32'(n <= cmi_pkg::BUSY_CYC), 32'h1);
  endtask

  task automatic t_idle();
    status_rd(32'h0000_0100, 32'h0000_3300);
    sram_ok <= 1'b0;
    status_rd(32'h0000_0000, 32'h0000_3300);
    sram_ok <= 1'b1;
    q = '{cmi_pkg::OP_TRACE_ID, 8'h00, 8'h00, 8'h00};
    frame(8);
    check(32'(val(8) >> 32), cmi_pkg::TRACE_ID[63:32]);
    check(32'(val(8)), cmi_pkg::TRACE_ID[31:0]);
    q = '{cmi_pkg::OP_ID_READ, 8'h00, 8'h00, 8'h00};
    frame(4);
    check(32'(val(4)), cmi_pkg::DEV_ID);
  endtask

  task automatic t_refused();
    q = '{cmi_pkg::OP_ERASE, 8'h08, 8'h00, 8'h00};
    frame(0);
    check(32'(status[cmi_pkg::ST_BUSY]), 32'h0);
    q = '{8'h55, 8'h01, 8'h02, 8'h03, 8'h04};
    frame(0);
    status_rd(32'h0000_0100, 32'h0000_3300);
  endtask

  task automatic t_enable();
    q = '{cmi_pkg::OP_TRANSPARENT_EN, 8'h08, 8'h00, 8'h00};
    frame(0);
    check(32'(status[cmi_pkg::ST_BUSY]), 32'h1);
    check(32'({taken, tri_o, halt}), 32'h4);
    wait_idle();
    status_rd(32'h0000_0200, 32'h0000_3300);
  endtask

  task automatic prog(input logic [7:0] seed);
    q = '{cmi_pkg::OP_USER_PROG, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < cmi_pkg::PAGE_BYTES; i++)
      q.push_back(seed + 8'(i * 7));
    frame(0);
    wait_idle();
  endtask

  task automatic read_pages(input logic [7:0] n, input logic [7:0] s0,
    input logic [7:0] s1);
    logic [7:0] e;
    q = '{cmi_pkg::OP_USER_READ, 8'h00, 8'h00, n};
    frame(16 * n);
    for (int i = 0; i < 16 * n; i++)
    begin
      e = (i < 16 ? s0 : s1) + 8'((i % 16) * 7);
      if (s0 == 8'h00 && s1 == 8'h00)
        e = 8'h00;
      check(32'(cmi_host_rx_i.got[i]), 32'(e));
    end
  endtask

  task automatic t_pages();
    q = '{cmi_pkg::OP_USER_ADDR_RST, 8'h00, 8'h00, 8'h00};
    frame(0);
    prog(8'h11);
    prog(8'hA3);
    stall <= 1'b1;
    q = '{cmi_pkg::OP_ADDR_LOAD, 8'h00, 8'h00, 8'h00,
          8'h40, 8'h00, 8'h00, 8'h01};
    frame(0);
    read_pages(8'h01, 8'hA3, 8'hA3);
    q = '{cmi_pkg::OP_USER_ADDR_RST, 8'h00, 8'h00, 8'h00};
    frame(0);
    read_pages(8'h02, 8'h11, 8'hA3);
    stall <= 1'b0;
    q = '{cmi_pkg::OP_ERASE, 8'h08, 8'h00, 8'h00};
    frame(0);
    check(32'(status[cmi_pkg::ST_BUSY]), 32'h1);
    q = '{cmi_pkg::OP_DISABLE, 8'h00, 8'h00};
    frame(0);
    check(32'(status[cmi_pkg::ST_ENABLE]), 32'h1);
    wait_idle();
    q = '{cmi_pkg::OP_USER_ADDR_RST, 8'h00, 8'h00, 8'h00};
    frame(0);
    read_pages(8'h02, 8'h00, 8'h00);
  endtask

  task automatic t_verify();
    logic [31:0] bad;
    bad = cmi_pkg::DEV_ID ^ 32'h0000_0001;
    q = '{cmi_pkg::OP_ID_COMPARE, 8'h00, 8'h00, 8'h00,
          bad[31:24], bad[23:16], bad[15:8], bad[7:0]};
    frame(0);
    status_rd(32'h0000_2200, 32'h0000_3200);
  endtask

  task automatic t_leave(input logic [7:0] sel);
    q = '{cmi_pkg::OP_ERASE, sel, 8'h00, 8'h00};
    frame(0);
    wait_idle();
    q = '{cmi_pkg::OP_DISABLE, 8'h00, 8'h00};
    frame(0);
    check(32'(status[cmi_pkg::ST_ENABLE]), 32'h0);
    check(32'(taken), 32'h1);
    q = '{cmi_pkg::OP_NULL};
    frame(0);
    check(32'({taken, tri_o, halt}), 32'h0);
  endtask

  task automatic t_offline();
    q = '{cmi_pkg::OP_OFFLINE_EN, 8'h00, 8'h00, 8'h00};
    frame(0);
    wait_idle();
    check(32'({tri_o, halt}), 32'h3);
    check(32'(status[cmi_pkg::ST_ENABLE]), 32'h1);
    t_leave(8'h01);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_idle();
    t_refused();
    t_enable();
    t_pages();
    t_verify();
    t_leave(8'h00);
    t_offline();
    wrap_up();
  end
endmodule

// *** tb/cmi_host_rx.sv ***
`timescale 1ns/100ps
module cmi_host_rx
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o
);
  logic [7:0] got[$];
  logic take;
  logic [7:0] seen;
  logic [2:0] phase;
  // Handshake is judged mid-cycle so the clock edge never races the core.
  always @(negedge clk_sys_i)
  begin
    take = rx_valid_i && rx_ready_o;
    seen = rx_data_i;
  end
  // When stalling, the host accepts only in two of every eight cycles.
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase <= 3'h0;
      rx_ready_o <= 1'b0;
    end
    else
    begin
      if (take)
        got.push_back(seen);
      phase <= phase + 3'h1;
      rx_ready_o <= !stall_i || (phase[2:1] == 2'h3);
    end
  end
endmodule
